/* File: shared/pcrc_params.svh */
// register offsets, field positions, reset values and the push width threshold for the crc block
`ifndef PCRC_PARAMS_SVH
`define PCRC_PARAMS_SVH

// byte offsets of the 32-bit register words
`define PCRC_OFS_CTRL_ONE 6'h00
`define PCRC_OFS_CTRL_TWO 6'h04
`define PCRC_OFS_POLY_LOW 6'h08
`define PCRC_OFS_POLY_HIGH 6'h0C
`define PCRC_OFS_DATA_LOW 6'h10
`define PCRC_OFS_DATA_HIGH 6'h14
`define PCRC_OFS_RES_LOW 6'h18
`define PCRC_OFS_RES_HIGH 6'h1C
`define PCRC_OFS_IRQ_STS 6'h20
`define PCRC_OFS_IRQ_MASK 6'h24

// crc_control_one fields
`define PCRC_B_ENABLE 0
`define PCRC_B_GO 1
`define PCRC_B_ISEL 2
`define PCRC_B_LSB 3
`define PCRC_B_FULL 4
`define PCRC_B_EMPTY 5
`define PCRC_F_COUNT_LO 8

// crc_control_two fields
`define PCRC_F_POLY_LENGTH_LO 0
`define PCRC_F_POLY_LENGTH_HI 4
`define PCRC_F_WIDTH_LO 8
`define PCRC_F_WIDTH_HI 12

// interrupt status and mask bits
`define PCRC_I_EMPTY 0
`define PCRC_I_DONE 1

// reset values
`define PCRC_RST_CTRL 5'h00
`define PCRC_RST_WORD 16'h0000
`define PCRC_RST_WIDTH 5'h0F

// a width field below this pushes on the low data write alone
`define PCRC_HALF_WIDTH 5'h10

`endif

/* File: shared/pcrc_pkg.sv */
// types shared by the crc block
package pcrc_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_TAIL} pcrc_state_e;
  typedef logic [31:0] pcrc_word_t;
  typedef logic [4:0] pcrc_len_t;
endpackage : pcrc_pkg

/* File: verif/pcrc_tb.sv */
// self-checking bench for the programmable crc block with a queue model
`timescale 1ns/1ps
`default_nettype none
`include "pcrc_params.svh"
module testbench;
  import pcrc_pkg::*;
  logic clk_sys;
  logic rst_n;
  logic [5:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  int miscompares;
  int n_compared;
  int m_poly_length;
  int m_width;
  int m_lsb;
  int m_cnt;
  logic [31:0] m_poly;
  logic [31:0] m_crc;
  logic [31:0] m_q[$];
  logic [31:0] rd;

  pcrc_top #(.FIFO_DEPTH(8)) i_dut (
    .CLK_SYS_I(clk_sys),
    .RST_N_I(rst_n),
    .AVS_ADDRESS_I(avs_address),
    .AVS_READ_I(avs_read),
    .AVS_WRITE_I(avs_write),
    .AVS_BYTEENABLE_I(avs_byteenable),
    .AVS_WRITEDATA_I(avs_writedata),
    .AVS_READDATA_O(avs_readdata),
    .AVS_WAITREQUEST_O(avs_waitrequest),
    .IRQ_O(irq)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic fail(input string msg);
    miscompares++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask : fail

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) fail($sformatf("reg got %h want %h", got, exp));
  endtask : cmp_reg

  task automatic cmp_irq(input logic exp);
    n_compared++;
    if (irq !== exp) fail("interrupt line level wrong");
  endtask : cmp_irq

  // the request is held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    avs_write <= wr;
    avs_read <= ~wr;
    avs_address <= a;
    avs_writedata <= d;
    // no cycle limit here: a slave that never grants is ended by the watchdog
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr_reg

  task automatic rd_reg(input logic [5:0] a);
    bus(1'b0, a, 32'h0000_0000);
  endtask : rd_reg

  // bit-serial reference, the result itself is never reversed
  function automatic logic [31:0] fold(input logic [31:0] c,
                                       input logic [31:0] w);
    logic [31:0] msk;
    logic fb;
    int k;
    msk = 32'hFFFF_FFFF >> (31 - m_poly_length);
    for (int i = 0; i <= m_width; i++) begin
      k = m_lsb ? i : m_width - i;
      fb = c[m_poly_length] ^ w[k];
      c = (c << 1) & msk;
      if (fb) c = c ^ (m_poly & msk);
    end
    return c;
  endfunction : fold

  // wide words need the high half to complete the push; full drops the word
  task automatic push(input logic [31:0] w);
    wr_reg(`PCRC_OFS_DATA_LOW, {16'h0000, w[15:0]});
    if (m_width >= 16) wr_reg(`PCRC_OFS_DATA_HIGH, {16'h0000, w[31:16]});
    if (m_cnt < 8) begin
      m_q.push_back(w);
      m_cnt++;
    end
  endtask : push

  task automatic run_case(input string name, input int poly_length, input int width,
      input int lsb, input int isel, input int nw, input int nr,
      input int clr, input int unmask);
    logic [31:0] ctl;
    logic [31:0] w;
    int n;
    int tail;
    m_poly_length = poly_length;
    m_width = width;
    m_lsb = lsb;
    m_poly = $urandom();
    tail = (poly_length + 1) / 2;
    ctl = 32'h1 | (32'(isel) << `PCRC_B_ISEL) | (32'(lsb) << `PCRC_B_LSB);
    wr_reg(`PCRC_OFS_CTRL_ONE, ctl);
    wr_reg(`PCRC_OFS_CTRL_TWO, (32'(width) << 8) | 32'(poly_length));
    wr_reg(`PCRC_OFS_POLY_LOW, {16'h0000, m_poly[15:0]});
    wr_reg(`PCRC_OFS_POLY_HIGH, {16'h0000, m_poly[31:16]});
    wr_reg(`PCRC_OFS_IRQ_MASK, unmask ? (isel ? 32'h2 : 32'h1) : 32'h0);
    rd_reg(`PCRC_OFS_IRQ_STS);
    if (clr) begin
      wr_reg(`PCRC_OFS_RES_LOW, 32'h0000_0000);
      wr_reg(`PCRC_OFS_RES_HIGH, 32'h0000_0000);
      m_crc = 32'h0000_0000;
    end
    m_q.delete();
    m_cnt = 0;
    for (int i = 0; i < nw; i++) begin
      w = $urandom();
      push(w);
    end
    n = m_q.size();
    rd_reg(`PCRC_OFS_CTRL_ONE);
    cmp_reg(rd, ctl | (32'(n) << `PCRC_F_COUNT_LO)
        | (n == 8 ? 32'h10 : 32'h0));
    wr_reg(`PCRC_OFS_CTRL_ONE, ctl | 32'h2);
    // refill while running: the engine drains a word per cycle
    // faster than the bus refills, so these words always find room
    m_cnt = 0;
    for (int i = 0; i < nr; i++) begin
      w = $urandom();
      push(w);
    end
    if (unmask) begin
      // a missing interrupt is ended by the watchdog
      while (irq !== 1'b1) begin
        @(posedge clk_sys);
      end
      rd_reg(`PCRC_OFS_CTRL_ONE);
      if (isel == 0 && tail > 4) cmp_reg(rd[1], 1'b1);
      if (isel == 1) cmp_reg(rd[1], 1'b0);
      repeat (tail + 2) @(posedge clk_sys);
    end else begin
      repeat (200) @(posedge clk_sys);
      cmp_irq(1'b0);
    end
    rd_reg(`PCRC_OFS_CTRL_ONE);
    cmp_reg(rd[1], 1'b0);
    rd_reg(`PCRC_OFS_IRQ_STS);
    cmp_reg(rd, isel ? 32'h2 : 32'h1);
    repeat (2) @(posedge clk_sys);
    cmp_irq(1'b0);
    foreach (m_q[i]) m_crc = fold(m_crc, m_q[i]);
    rd_reg(`PCRC_OFS_RES_LOW);
    cmp_reg(rd, {16'h0000, m_crc[15:0]});
    rd_reg(`PCRC_OFS_RES_HIGH);
    cmp_reg(rd, {16'h0000, m_crc[31:16]});
    $display("test %s done", name);
  endtask : run_case

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #100us;
    fail("watchdog expired");
    wrap_up();
  end

  initial begin
    rst_n = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'hF;
    avs_writedata = 32'h0000_0000;
    miscompares = 0;
    n_compared = 0;
    m_crc = 32'h0000_0000;
    void'($urandom(23));
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd_reg(`PCRC_OFS_CTRL_ONE);
    // empty flag reads one out of reset
    cmp_reg(rd, 32'h0000_0020);
    rd_reg(`PCRC_OFS_CTRL_TWO);
    cmp_reg(rd, 32'h0000_0F00);
    rd_reg(`PCRC_OFS_IRQ_MASK);
    cmp_reg(rd, 32'h0000_0000);
    // unmapped place reads zero and ignores writes
    wr_reg(6'h28, 32'h0000_FFFF);
    rd_reg(6'h28);
    cmp_reg(rd, 32'h0000_0000);
    $display("test reset_values done");
    run_case("msb_bytes", 31, 7, 0, 0, 6, 2, 1, 1);
    run_case("lsb_overfill", 15, 31, 1, 1, 9, 1, 1, 1);
    run_case("resume_masked", 15, 12, 0, 1, 3, 0, 0, 0);
    for (int i = 0; i < 4; i++) begin
      run_case("random", $urandom_range(31, 3), $urandom_range(31, 0),
               $urandom_range(1, 0), $urandom_range(1, 0),
               $urandom_range(8, 1), 0, 1, 1);
    end
    // software clearing go must not flag completion
    wr_reg(`PCRC_OFS_IRQ_MASK, 32'h2);
    wr_reg(`PCRC_OFS_CTRL_TWO, 32'h0000_0F1F);
    wr_reg(`PCRC_OFS_CTRL_ONE, 32'h0000_0007);
    wr_reg(`PCRC_OFS_CTRL_ONE, 32'h0000_0005);
    repeat (40) @(posedge clk_sys);
    cmp_irq(1'b0);
    rd_reg(`PCRC_OFS_IRQ_STS);
    cmp_reg(rd, 32'h0000_0000);
    $display("test soft_clear done");
    wrap_up();
  end
endmodule : testbench
`default_nettype wire

/* File: verilog/pcrc_engine.sv */
// combinational crc step: folds one fifo word into the running crc
`timescale 1ns/1ps
`default_nettype none
module pcrc_engine
  import pcrc_pkg::*;
(
  // running value and polynomial
  input wire pcrc_pkg::pcrc_word_t crc_i,
  input wire pcrc_pkg::pcrc_word_t poly_i,
  input wire pcrc_pkg::pcrc_len_t poly_length_i,
  // data word and its shape
  input wire pcrc_pkg::pcrc_word_t data_i,
  input wire pcrc_pkg::pcrc_len_t input_width_i,
  input wire logic lsb_first_select_i,
  // folded value
  output pcrc_pkg::pcrc_word_t crc_o
);
  function automatic pcrc_word_t fold(input pcrc_word_t crc,
      input pcrc_word_t poly, input pcrc_len_t poly_length,
      input pcrc_word_t data, input pcrc_len_t width, input logic lsb);
    pcrc_word_t mask;
    pcrc_word_t c;
    logic din;
    logic fb;
    mask = 32'hFFFFFFFF >> (5'h1F - poly_length);
    c = crc & mask;
    for (int i = 0; i < 32; i++) begin
      if (i <= int'(width)) begin
        din = lsb ? data[i] : data[int'(width) - i];
        fb = c[poly_length] ^ din;
        c = (c << 1) & mask;
        if (fb) begin
          c = c ^ (poly & mask);
        end
      end
    end
    fold = c;
  endfunction : fold

  assign crc_o = fold(crc_i, poly_i, poly_length_i, data_i, input_width_i,
      lsb_first_select_i);
endmodule : pcrc_engine
`default_nettype wire

/* File: verilog/pcrc_top.sv */
// programmable crc generator with input fifo and avalon-mm register slave
`timescale 1ns/1ps
`default_nettype none
`include "pcrc_params.svh"
module pcrc_top
  import pcrc_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  // avalon-mm slave
  input wire logic [5:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // interrupt
  output logic IRQ_O
);
  import pcrc_pkg::*;

  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam int AW = $clog2(FIFO_DEPTH);
  localparam logic [CW-1:0] DEPTH_C = CW'(FIFO_DEPTH);
  localparam logic [CW-1:0] ONE_C = CW'(1);

  function automatic logic [15:0] merge(input logic [15:0] old,
      input logic [31:0] wd, input logic [3:0] be);
    merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : merge

  // control and configuration
  logic engine_enable_q;
  logic calc_go_q;
  logic irq_condition_select_q;
  logic lsb_first_select_q;
  pcrc_len_t poly_length_q;
  pcrc_len_t input_width_q;
  logic [15:0] poly_terms_low_q;
  logic [15:0] poly_terms_high_q;
  logic [15:0] input_data_low_q;
  logic [31:0] result_q;
  logic [1:0] irq_sts_q;
  logic [1:0] irq_mask_q;
  // bus handshake
  logic ack_q;
  logic wr_acc;
  logic rd_acc;
  logic [15:0] wlow;
  // fifo
  pcrc_word_t fifo_mem [FIFO_DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [CW-1:0] fifo_word_count_q;
  logic fifo_full_flag;
  logic push;
  logic pop;
  pcrc_word_t push_word;
  // engine sequencing
  pcrc_state_e state_q;
  pcrc_len_t tail_cnt_q;
  pcrc_len_t tail_len;
  logic [5:0] tail_sum;
  logic tail_done;
  logic go_sw_clear;
  logic empty_event;
  pcrc_word_t crc_next;

  // request is taken on the edge after waitrequest went low
  assign wr_acc = AVS_WRITE_I && !AVS_WAITREQUEST_O;
  assign rd_acc = AVS_READ_I && !AVS_WAITREQUEST_O;
  assign wlow = merge(16'h0000, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);

  // one wait cycle, then a single-cycle grant; back to busy after it
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      ack_q <= 1'b0;
      AVS_WAITREQUEST_O <= 1'b1;
    end else begin
      ack_q <= (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O && !ack_q;
      AVS_WAITREQUEST_O <= !((AVS_READ_I || AVS_WRITE_I)
          && AVS_WAITREQUEST_O && !ack_q);
    end
  end

  // read data registered at the grant, unmapped words read zero
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      AVS_READDATA_O <= 32'h00000000;
    end else if (AVS_READ_I && AVS_WAITREQUEST_O && !ack_q) begin
      AVS_READDATA_O <= 32'h00000000;
      unique case (AVS_ADDRESS_I)
        `PCRC_OFS_CTRL_ONE: begin
          AVS_READDATA_O[`PCRC_B_ENABLE] <= engine_enable_q;
          AVS_READDATA_O[`PCRC_B_GO] <= calc_go_q;
          AVS_READDATA_O[`PCRC_B_ISEL] <= irq_condition_select_q;
          AVS_READDATA_O[`PCRC_B_LSB] <= lsb_first_select_q;
          AVS_READDATA_O[`PCRC_B_FULL] <= fifo_full_flag;
          AVS_READDATA_O[`PCRC_B_EMPTY] <= fifo_word_count_q == '0;
          AVS_READDATA_O[`PCRC_F_COUNT_LO +: CW] <= fifo_word_count_q;
        end
        `PCRC_OFS_CTRL_TWO: begin
          AVS_READDATA_O[`PCRC_F_POLY_LENGTH_HI:`PCRC_F_POLY_LENGTH_LO] <= poly_length_q;
          AVS_READDATA_O[`PCRC_F_WIDTH_HI:`PCRC_F_WIDTH_LO] <= input_width_q;
        end
        `PCRC_OFS_POLY_LOW: AVS_READDATA_O[15:0] <= poly_terms_low_q;
        `PCRC_OFS_POLY_HIGH: AVS_READDATA_O[15:0] <= poly_terms_high_q;
        `PCRC_OFS_DATA_LOW: AVS_READDATA_O[15:0] <= input_data_low_q;
        `PCRC_OFS_RES_LOW: AVS_READDATA_O[15:0] <= result_q[15:0];
        `PCRC_OFS_RES_HIGH: AVS_READDATA_O[15:0] <= result_q[31:16];
        `PCRC_OFS_IRQ_STS: AVS_READDATA_O[1:0] <= irq_sts_q;
        `PCRC_OFS_IRQ_MASK: AVS_READDATA_O[1:0] <= irq_mask_q;
        default: AVS_READDATA_O <= 32'h00000000;
      endcase
    end
  end

  // configuration registers
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      engine_enable_q <= 1'b0;
      irq_condition_select_q <= 1'b0;
      lsb_first_select_q <= 1'b0;
      poly_length_q <= `PCRC_RST_CTRL;
      input_width_q <= `PCRC_RST_WIDTH;
      poly_terms_low_q <= `PCRC_RST_WORD;
      poly_terms_high_q <= `PCRC_RST_WORD;
      input_data_low_q <= `PCRC_RST_WORD;
      irq_mask_q <= 2'h0;
    end else if (wr_acc) begin
      unique case (AVS_ADDRESS_I)
        `PCRC_OFS_CTRL_ONE: begin
          if (AVS_BYTEENABLE_I[0]) begin
            engine_enable_q <= AVS_WRITEDATA_I[`PCRC_B_ENABLE];
            irq_condition_select_q <= AVS_WRITEDATA_I[`PCRC_B_ISEL];
            lsb_first_select_q <= AVS_WRITEDATA_I[`PCRC_B_LSB];
          end
        end
        `PCRC_OFS_CTRL_TWO: begin
          if (AVS_BYTEENABLE_I[0]) begin
            poly_length_q <= AVS_WRITEDATA_I[`PCRC_F_POLY_LENGTH_HI:`PCRC_F_POLY_LENGTH_LO];
          end
          if (AVS_BYTEENABLE_I[1]) begin
            input_width_q <=
                AVS_WRITEDATA_I[`PCRC_F_WIDTH_HI:`PCRC_F_WIDTH_LO];
          end
        end
        `PCRC_OFS_POLY_LOW: begin
          poly_terms_low_q <= merge(poly_terms_low_q, AVS_WRITEDATA_I,
              AVS_BYTEENABLE_I);
        end
        `PCRC_OFS_POLY_HIGH: begin
          poly_terms_high_q <= merge(poly_terms_high_q, AVS_WRITEDATA_I,
              AVS_BYTEENABLE_I);
        end
        `PCRC_OFS_DATA_LOW: input_data_low_q <= wlow;
        `PCRC_OFS_IRQ_MASK: irq_mask_q <= AVS_WRITEDATA_I[1:0];
        default: irq_mask_q <= irq_mask_q;
      endcase
    end
  end

  // narrow data pushes on the low write; wide data waits for the high half
  always_comb begin
    push = 1'b0;
    push_word = {16'h0000, wlow};
    if (wr_acc && AVS_ADDRESS_I == `PCRC_OFS_DATA_LOW
        && input_width_q < `PCRC_HALF_WIDTH) begin
      push = 1'b1;
    end else if (wr_acc && AVS_ADDRESS_I == `PCRC_OFS_DATA_HIGH) begin
      push = 1'b1;
      push_word = {wlow, input_data_low_q};
    end
    // words written while full are dropped, software watches the flag
    if (fifo_full_flag) begin
      push = 1'b0;
    end
  end

  assign fifo_full_flag = fifo_word_count_q == DEPTH_C;
  assign pop = state_q == ST_RUN && fifo_word_count_q != '0;
  assign empty_event = pop && !push && fifo_word_count_q == ONE_C;

  always_ff @(posedge CLK_SYS_I) begin
    if (push) begin
      fifo_mem[wr_ptr_q] <= push_word;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      fifo_word_count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q == AW'(FIFO_DEPTH - 1) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q == AW'(FIFO_DEPTH - 1) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        fifo_word_count_q <= fifo_word_count_q + ONE_C;
      end else if (pop && !push) begin
        fifo_word_count_q <= fifo_word_count_q - ONE_C;
      end
    end
  end

  pcrc_engine u_engine (
    .crc_i(result_q),
    .poly_i({poly_terms_high_q, poly_terms_low_q}),
    .poly_length_i(poly_length_q),
    .data_i(fifo_mem[rd_ptr_q]),
    .input_width_i(input_width_q),
    .lsb_first_select_i(lsb_first_select_q),
    .crc_o(crc_next)
  );

  // result pair: software write beats an engine update in the same cycle
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      result_q <= 32'h00000000;
    end else if (wr_acc && AVS_ADDRESS_I == `PCRC_OFS_RES_LOW) begin
      result_q[15:0] <= merge(result_q[15:0], AVS_WRITEDATA_I,
          AVS_BYTEENABLE_I);
    end else if (wr_acc && AVS_ADDRESS_I == `PCRC_OFS_RES_HIGH) begin
      result_q[31:16] <= merge(result_q[31:16], AVS_WRITEDATA_I,
          AVS_BYTEENABLE_I);
    end else if (pop) begin
      result_q <= crc_next;
    end
  end

  // the last word is folded at pop; the tail models the engine drain time
  // one bit wider so that a length of 31 drains 16 cycles instead of wrapping
  assign tail_sum = {1'b0, poly_length_q} + 6'h01;
  assign tail_len = tail_sum[5:1] == 5'h00 ? 5'h01 : tail_sum[5:1];
  assign tail_done = state_q == ST_TAIL && tail_cnt_q == 5'h01;
  assign go_sw_clear = wr_acc && AVS_ADDRESS_I == `PCRC_OFS_CTRL_ONE
      && AVS_BYTEENABLE_I[0] && !AVS_WRITEDATA_I[`PCRC_B_GO];

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      state_q <= ST_IDLE;
      tail_cnt_q <= 5'h00;
    end else if (!calc_go_q || !engine_enable_q || go_sw_clear) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: state_q <= ST_RUN;
        ST_RUN: begin
          if (empty_event || fifo_word_count_q == '0) begin
            state_q <= ST_TAIL;
            tail_cnt_q <= tail_len;
          end
        end
        ST_TAIL: begin
          tail_cnt_q <= tail_cnt_q - 5'h01;
          if (tail_done) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      calc_go_q <= 1'b0;
    end else if (wr_acc && AVS_ADDRESS_I == `PCRC_OFS_CTRL_ONE
        && AVS_BYTEENABLE_I[0]) begin
      calc_go_q <= AVS_WRITEDATA_I[`PCRC_B_GO] && !tail_done;
    end else if (tail_done) begin
      calc_go_q <= 1'b0;
    end
  end

  // sticky status, cleared by reading it; a new event wins over the clear
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      irq_sts_q <= 2'h0;
    end else begin
      if (rd_acc && AVS_ADDRESS_I == `PCRC_OFS_IRQ_STS) begin
        irq_sts_q <= 2'h0;
      end
      if (empty_event && !irq_condition_select_q) begin
        irq_sts_q[`PCRC_I_EMPTY] <= 1'b1;
      end
      if (tail_done && irq_condition_select_q && !go_sw_clear) begin
        irq_sts_q[`PCRC_I_DONE] <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(irq_sts_q & irq_mask_q);
    end
  end

  AST_EMPTY_IRQ: assert property (@(posedge CLK_SYS_I)
    disable iff (!RST_N_I)
    (empty_event && !irq_condition_select_q) |=> irq_sts_q[`PCRC_I_EMPTY])
    else $error("empty event did not set status");
  AST_DONE_IRQ: assert property (@(posedge CLK_SYS_I)
    disable iff (!RST_N_I)
    (tail_done && irq_condition_select_q && !go_sw_clear)
        |=> irq_sts_q[`PCRC_I_DONE] && !calc_go_q)
    else $error("completion did not set done status");
  AST_SW_CLEAR_QUIET: assert property (@(posedge CLK_SYS_I)
    disable iff (!RST_N_I)
    (go_sw_clear && !tail_done) |=> !$rose(irq_sts_q[`PCRC_I_DONE]))
    else $error("software clear of go raised done");
  AST_TAIL_LEN: assert property (@(posedge CLK_SYS_I)
    disable iff (!RST_N_I)
    (state_q == ST_RUN && empty_event && calc_go_q && engine_enable_q
        && !go_sw_clear) |=> state_q == ST_TAIL && tail_cnt_q == tail_len)
    else $error("drain time not loaded after empty");
  AST_GO_CLEARS: assert property (@(posedge CLK_SYS_I)
    disable iff (!RST_N_I)
    tail_done |=> !calc_go_q && state_q == ST_IDLE)
    else $error("go not cleared at completion");
  AST_START: assert property (@(posedge CLK_SYS_I)
    disable iff (!RST_N_I)
    (state_q == ST_IDLE && calc_go_q && engine_enable_q && !go_sw_clear)
        |=> state_q == ST_RUN)
    else $error("go did not start the run");
  AST_RESULT_WRITE: assert property (@(posedge CLK_SYS_I)
    disable iff (!RST_N_I)
    (wr_acc && AVS_ADDRESS_I == `PCRC_OFS_RES_LOW
        && AVS_BYTEENABLE_I == 4'hF) |=> result_q[15:0] == $past(wlow))
    else $error("result low write lost");
  AST_POP_FOLD: assert property (@(posedge CLK_SYS_I)
    disable iff (!RST_N_I)
    (pop && !(wr_acc && (AVS_ADDRESS_I == `PCRC_OFS_RES_LOW
        || AVS_ADDRESS_I == `PCRC_OFS_RES_HIGH)))
        |=> result_q == $past(crc_next) && fifo_word_count_q != DEPTH_C)
    else $error("popped word not folded");
  AST_FULL_FLAG: assert property (@(posedge CLK_SYS_I)
    disable iff (!RST_N_I)
    (fifo_full_flag && !pop) |=> fifo_word_count_q == DEPTH_C)
    else $error("full fifo count changed without pop");
  AST_BUS_GRANT: assert property (@(posedge CLK_SYS_I)
    disable iff (!RST_N_I)
    !AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("waitrequest low for more than one cycle");
endmodule : pcrc_top
`default_nettype wire
